// ### core/dpm_defs.svh
// Purpose: Shared constants for the dual-port memory output pipeline.
// Assumes: Included by its bare name from the design files.
// Notes:   Offsets of the software control block and field positions.
`ifndef DPM_DEFS_SVH
`define DPM_DEFS_SVH

// Byte addresses of the control registers.
`define DPM_OFF_CTRL     32'h0000_0000
`define DPM_OFF_STATUS   32'h0000_0004
// Control register field positions.
`define DPM_CTRL_A_MODE  1:0
`define DPM_CTRL_B_MODE  3:2
`define DPM_CTRL_A_CLEAR 4
`define DPM_CTRL_B_CLEAR 5
// Control register value after reset: both ports read first, no clear.
`define DPM_CTRL_RESET   32'h0000_0000
// Write mode encodings.
`define DPM_MODE_READ_FIRST  2'h0
`define DPM_MODE_WRITE_FIRST 2'h1
`define DPM_MODE_HOLD        2'h2
// Default fill value for locations without explicit initial contents.
`define DPM_FILL_DEFAULT 32'h0000_0000

`endif

// ### core/dpm_pkg.sv
// Purpose: Types for the dual-port memory output pipeline.
// Assumes: Used with explicit scope, never imported.
// Notes:   Encodings mirror the constants in the header.
package dpm_pkg;

	// Behaviour of the read data on a write.
	typedef enum logic [1:0] {
		DPM_READ_FIRST  = 2'b00,
		DPM_WRITE_FIRST = 2'b01,
		DPM_HOLD        = 2'b10
	} dpm_mode_t;

	// AHB bus slave phase.
	typedef enum logic [0:0] {
		DPM_BUS_IDLE = 1'b0,
		DPM_BUS_DATA = 1'b1
	} dpm_bus_t;

endpackage : dpm_pkg

// ### core/dpm_port.sv
// Purpose: One stage of a memory port's output pipeline: the primitive stage or a mux stage.
// Assumes: Raw read data enters one cycle after the access edge.
// Notes:   Each primitive or mux stage is one instance of this module chained by the top; the core stage is in the top.
`timescale 1ns/1ns

module dpm_port #(
	parameter int WIDTH      = 32,
	parameter bit USE_STAGE  = 1'b1,
	parameter bit ASYNC_CLR  = 1'b0,
	parameter bit CLEAR_OVER = 1'b1
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             gate,
	input  wire logic             clear,
	input  wire logic [WIDTH-1:0] clear_value,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage_q;
	logic             clr_eff;

	// With the gate dominating, a clear only acts while the stage is enabled.
	assign clr_eff = CLEAR_OVER ? clear : (clear & gate);

	generate
		if (!USE_STAGE) begin : g_pass
			assign dout = din;
		end else if (ASYNC_CLR) begin : g_async
			// Asynchronous clear takes the stage at once, without a clock edge.
			always_ff @(posedge hclk or negedge hresetn or posedge clear) begin
				if (!hresetn) begin
					stage_q <= '0;
				end else if (clear) begin
					stage_q <= clear_value;
				end else if (gate) begin
					stage_q <= din;
				end
			end
			assign dout = stage_q;
		end else begin : g_sync
			// Synchronous clear with configured priority against the gate.
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					stage_q <= '0;
				end else if (clr_eff) begin
					stage_q <= clear_value;
				end else if (gate) begin
					stage_q <= din;
				end
			end
			assign dout = stage_q;
		end
	endgenerate

endmodule : dpm_port

// ### core/dpm_top.sv
// Purpose: Dual-port memory with configurable write modes and output pipeline.
// Assumes: Both ports run on hclk; user logic keeps its own enable rules.
// Notes:   Write modes and software clears are set over an AHB-Lite slave.
`timescale 1ns/1ns
`include "dpm_defs.svh"

module dpm_top #(
	parameter int          WIDTH       = 32,
	parameter int          DEPTH       = 1024,
	parameter int          AW          = 10,
	parameter int          PRIM_DEPTH  = 512,
	parameter bit          A_HAS_GATE  = 1'b1,
	parameter bit          B_HAS_GATE  = 1'b1,
	parameter bit          A_PRIM_REG  = 1'b1,
	parameter bit          B_PRIM_REG  = 1'b1,
	parameter bit          A_CORE_REG  = 1'b1,
	parameter bit          B_CORE_REG  = 1'b1,
	parameter bit          A_FINAL_PIN = 1'b0,
	parameter bit          B_FINAL_PIN = 1'b0,
	parameter int          MUX_STAGES  = 0,
	parameter bit          A_HAS_CLEAR = 1'b1,
	parameter bit          B_HAS_CLEAR = 1'b1,
	parameter bit          A_CLR_OVER  = 1'b1,
	parameter bit          B_CLR_OVER  = 1'b1,
	parameter bit          A_LATCH_CLR = 1'b0,
	parameter bit          B_LATCH_CLR = 1'b0,
	parameter bit          ASYNC_CLR   = 1'b0,
	parameter logic [31:0] A_CLR_VALUE = 32'h0000_0000,
	parameter logic [31:0] B_CLR_VALUE = 32'h0000_0000,
	parameter int          INIT_COUNT  = 0,
	parameter logic [31:0] INIT_VALUE  = 32'h0000_0000,
	parameter logic [31:0] FILL_VALUE  = `DPM_FILL_DEFAULT
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// AHB-Lite slave.
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic             hready,
	input  wire logic [31:0]      hwdata,
	output logic      [31:0]      hrdata,
	output logic                  hreadyout,
	output logic                  hresp,
	// Port A.
	input  wire logic             port_a_access_gate,
	input  wire logic             port_a_write,
	input  wire logic [AW-1:0]    port_a_addr,
	input  wire logic [WIDTH-1:0] port_a_wdata,
	input  wire logic             port_a_final_stage_gate,
	input  wire logic             port_a_output_clear,
	output logic      [WIDTH-1:0] port_a_rdata,
	// Port B.
	input  wire logic             port_b_access_gate,
	input  wire logic             port_b_write,
	input  wire logic [AW-1:0]    port_b_addr,
	input  wire logic [WIDTH-1:0] port_b_wdata,
	input  wire logic             port_b_final_stage_gate,
	input  wire logic             port_b_output_clear,
	output logic      [WIDTH-1:0] port_b_rdata
);

	////////////////////////////////////////////////////////////////////////
	// Configuration checks and derived constants.

	// The mux stages exist only with both core stages and a deep memory.
	localparam bool_mux_ok = A_CORE_REG && B_CORE_REG && (DEPTH > PRIM_DEPTH);
	localparam int MUXS = bool_mux_ok ? ((MUX_STAGES > 3) ? 3 : MUX_STAGES) : 0;
	// The latch clear is honoured only in its legal configuration.
	localparam bit A_LATCH = A_LATCH_CLR && A_HAS_CLEAR && A_PRIM_REG && !A_CORE_REG;
	localparam bit B_LATCH = B_LATCH_CLR && B_HAS_CLEAR && B_PRIM_REG && !B_CORE_REG;
	// Latency: one for the array read plus each enabled stage.
	localparam int A_LATENCY = 1 + int'(A_PRIM_REG) + MUXS + int'(A_CORE_REG);
	localparam int B_LATENCY = 1 + int'(B_PRIM_REG) + MUXS + int'(B_CORE_REG);

	////////////////////////////////////////////////////////////////////////
	// Control register and AHB-Lite slave.

	logic [31:0]      ctrl_q;
	logic             wr_pend_q;
	logic             rd_pend_q;
	logic [31:0]      addr_q;
	logic             take;
	dpm_pkg::dpm_mode_t a_mode;
	dpm_pkg::dpm_mode_t b_mode;

	assign take = hsel && hready && htrans[1];
	assign a_mode = dpm_pkg::dpm_mode_t'(ctrl_q[`DPM_CTRL_A_MODE]);
	assign b_mode = dpm_pkg::dpm_mode_t'(ctrl_q[`DPM_CTRL_B_MODE]);

	// Address phase capture; every transfer finishes with no wait state.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q    <= 32'h0000_0000;
		end else begin
			wr_pend_q <= take && hwrite;
			rd_pend_q <= take && !hwrite;
			if (take) begin
				addr_q <= haddr;
			end
		end
	end

	// Control register write in the data phase; unmapped writes are dropped.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= `DPM_CTRL_RESET;
		end else if (wr_pend_q && addr_q == `DPM_OFF_CTRL) begin
			ctrl_q <= {26'h000_0000, hwdata[5:0]};
		end
	end

	// Read data is registered; status shows the latency of each port.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			case (haddr)
				`DPM_OFF_CTRL:   hrdata <= ctrl_q;
				`DPM_OFF_STATUS: hrdata <= {16'h0000, A_LATENCY[7:0], B_LATENCY[7:0]};
				default:         hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// Zero-wait slave with OKAY responses only.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Memory array and initial contents.

	logic [WIDTH-1:0] mem [DEPTH];

	// Contents start from the init list and the default fill elsewhere.
	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			mem[i] = (i < INIT_COUNT) ? INIT_VALUE[WIDTH-1:0] : FILL_VALUE[WIDTH-1:0];
		end
	end

	logic en_a;
	logic en_b;
	logic [WIDTH-1:0] raw_a_q;
	logic [WIDTH-1:0] raw_b_q;

	// A port without an enable input is always on.
	assign en_a = A_HAS_GATE ? port_a_access_gate : 1'b1;
	assign en_b = B_HAS_GATE ? port_b_access_gate : 1'b1;

	// Array writes from both ports; port B wins on a shared address.
	always_ff @(posedge hclk) begin
		if (en_a && port_a_write) begin
			mem[port_a_addr] <= port_a_wdata;
		end
		if (en_b && port_b_write) begin
			mem[port_b_addr] <= port_b_wdata;
		end
	end

	// Port A raw output latch with write mode and clear handling.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			raw_a_q <= '0;
		end else if (A_LATCH && port_a_output_clear) begin
			raw_a_q <= A_CLR_VALUE[WIDTH-1:0];
		end else if (en_a) begin
			if (!port_a_write) begin
				raw_a_q <= mem[port_a_addr];
			end else begin
				case (a_mode)
					dpm_pkg::DPM_READ_FIRST:  raw_a_q <= mem[port_a_addr];
					dpm_pkg::DPM_WRITE_FIRST: raw_a_q <= port_a_wdata;
					dpm_pkg::DPM_HOLD:        raw_a_q <= raw_a_q;
					default:                  raw_a_q <= mem[port_a_addr];
				endcase
			end
		end
	end

	// Port B raw output latch with write mode and clear handling.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			raw_b_q <= '0;
		end else if (B_LATCH && port_b_output_clear) begin
			raw_b_q <= B_CLR_VALUE[WIDTH-1:0];
		end else if (en_b) begin
			if (!port_b_write) begin
				raw_b_q <= mem[port_b_addr];
			end else begin
				case (b_mode)
					dpm_pkg::DPM_READ_FIRST:  raw_b_q <= mem[port_b_addr];
					dpm_pkg::DPM_WRITE_FIRST: raw_b_q <= port_b_wdata;
					dpm_pkg::DPM_HOLD:        raw_b_q <= raw_b_q;
					default:                  raw_b_q <= mem[port_b_addr];
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output pipelines.

	logic clr_a;
	logic clr_b;
	logic fin_a;
	logic fin_b;
	logic [WIDTH-1:0] a_stage [5];
	logic [WIDTH-1:0] b_stage [5];

	// Clear inputs count only when configured; software can force them too.
	assign clr_a = (A_HAS_CLEAR && port_a_output_clear) || ctrl_q[`DPM_CTRL_A_CLEAR];
	assign clr_b = (B_HAS_CLEAR && port_b_output_clear) || ctrl_q[`DPM_CTRL_B_CLEAR];
	// The last stage has its own gate when the pin is used.
	assign fin_a = A_FINAL_PIN ? port_a_final_stage_gate : en_a;
	assign fin_b = B_FINAL_PIN ? port_b_final_stage_gate : en_b;

	assign a_stage[0] = raw_a_q;
	assign b_stage[0] = raw_b_q;

	// Stages: primitive, three possible mux stages, core; last uses final gate.
	genvar s;
	generate
		for (s = 0; s < 5; s++) begin : g_stage
			localparam bit A_ON = (s == 0) ? A_PRIM_REG : (s == 4) ? A_CORE_REG : (s <= MUXS);
			localparam bit B_ON = (s == 0) ? B_PRIM_REG : (s == 4) ? B_CORE_REG : (s <= MUXS);
			localparam bit A_LAST = (s == 4) ? A_CORE_REG : (!A_CORE_REG && s == 0 && MUXS == 0);
			localparam bit B_LAST = (s == 4) ? B_CORE_REG : (!B_CORE_REG && s == 0 && MUXS == 0);
			if (s < 4) begin : g_link
				dpm_port #(
					.WIDTH      (WIDTH),
					.USE_STAGE  (A_ON),
					.ASYNC_CLR  (ASYNC_CLR),
					.CLEAR_OVER (A_CLR_OVER)
				) u_a (
					.hclk        (hclk),
					.hresetn     (hresetn),
					.gate        (A_LAST ? fin_a : en_a),
					.clear       (clr_a),
					.clear_value (A_CLR_VALUE[WIDTH-1:0]),
					.din         (a_stage[s]),
					.dout        (a_stage[s+1])
				);
				dpm_port #(
					.WIDTH      (WIDTH),
					.USE_STAGE  (B_ON),
					.ASYNC_CLR  (ASYNC_CLR),
					.CLEAR_OVER (B_CLR_OVER)
				) u_b (
					.hclk        (hclk),
					.hresetn     (hresetn),
					.gate        (B_LAST ? fin_b : en_b),
					.clear       (clr_b),
					.clear_value (B_CLR_VALUE[WIDTH-1:0]),
					.din         (b_stage[s]),
					.dout        (b_stage[s+1])
				);
			end
		end
	endgenerate

	// Core output stage always exists as a flop so the outputs are registered.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_a_rdata <= '0;
			port_b_rdata <= '0;
		end else begin
			if (clr_a && (A_CLR_OVER || fin_a)) begin
				port_a_rdata <= A_CLR_VALUE[WIDTH-1:0];
			end else if (fin_a || !A_CORE_REG) begin
				port_a_rdata <= a_stage[4];
			end
			if (clr_b && (B_CLR_OVER || fin_b)) begin
				port_b_rdata <= B_CLR_VALUE[WIDTH-1:0];
			end else if (fin_b || !B_CORE_REG) begin
				port_b_rdata <= b_stage[4];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions.

	// Hold mode: a write does not disturb the raw port B latch.
	a_hold_keeps_b: assert property (@(posedge hclk) disable iff (!hresetn)
		(en_b && port_b_write && b_mode == dpm_pkg::DPM_HOLD && !B_LATCH)
		|=> $stable(raw_b_q)) else $error("port b hold mode changed output");
	// Write-first mode shows the new data one edge later.
	a_wfirst_b_data: assert property (@(posedge hclk) disable iff (!hresetn)
		(en_b && port_b_write && b_mode == dpm_pkg::DPM_WRITE_FIRST && !B_LATCH)
		|=> raw_b_q == $past(port_b_wdata)) else $error("port b write first wrong");
	// Write-first mode on port A.
	a_wfirst_a_data: assert property (@(posedge hclk) disable iff (!hresetn)
		(en_a && port_a_write && a_mode == dpm_pkg::DPM_WRITE_FIRST && !A_LATCH)
		|=> raw_a_q == $past(port_a_wdata)) else $error("port a write first wrong");
	// Hold mode on port A.
	a_hold_keeps_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(en_a && port_a_write && a_mode == dpm_pkg::DPM_HOLD && !A_LATCH)
		|=> $stable(raw_a_q)) else $error("port a hold mode changed output");
	// A disabled port B keeps its raw latch.
	a_gate_b_idle: assert property (@(posedge hclk) disable iff (!hresetn)
		(!en_b && !(B_LATCH && port_b_output_clear)) |=> $stable(raw_b_q))
		else $error("port b moved while disabled");
	// A disabled port A keeps its raw latch.
	a_gate_a_idle: assert property (@(posedge hclk) disable iff (!hresetn)
		(!en_a && !(A_LATCH && port_a_output_clear)) |=> $stable(raw_a_q))
		else $error("port a moved while disabled");
	// A dominant clear reaches the port A output on the next edge.
	a_clear_a_out: assert property (@(posedge hclk) disable iff (!hresetn)
		(clr_a && A_CLR_OVER) |=> port_a_rdata == A_CLR_VALUE[WIDTH-1:0])
		else $error("port a clear not applied");
	// A dominant clear reaches the port B output on the next edge.
	a_clear_b_out: assert property (@(posedge hclk) disable iff (!hresetn)
		(clr_b && B_CLR_OVER) |=> port_b_rdata == B_CLR_VALUE[WIDTH-1:0])
		else $error("port b clear not applied");
	// Without the final gate and clear, a core-registered output holds.
	a_final_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(A_CORE_REG && !fin_a && !clr_a) |=> $stable(port_a_rdata))
		else $error("port a final stage moved");
	// Without the final gate and clear, a core-registered port B output holds.
	a_final_hold_b: assert property (@(posedge hclk) disable iff (!hresetn)
		(B_CORE_REG && !fin_b && !clr_b) |=> $stable(port_b_rdata))
		else $error("port b final stage moved");

endmodule : dpm_top

// ### verif/dpm_user.sv
// Purpose: User logic model that drives one memory port.
// Assumes: The bench hands it one request a cycle, a cycle ahead.
// Notes:   Idle address and data lines toggle so a stale value never passes.
`timescale 1ns/1ns

module dpm_user #(
	parameter int AW = 10,
	parameter int W  = 32
) (
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          req,
	input  wire logic          req_wr,
	input  wire logic [AW-1:0] req_addr,
	input  wire logic [W-1:0]  req_data,
	output logic               gate,
	output logic               write,
	output logic      [AW-1:0] addr,
	output logic      [W-1:0]  wdata
);
	////////////////////////////////////////////////////////////////////////
	// Signals change just after the edge; released lines show the inverse
	// of their last value, because a simulator would settle an unknown freely.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gate  <= 1'b0;
			write <= 1'b0;
			addr  <= '0;
			wdata <= '0;
		end else if (req) begin
			gate  <= 1'b1;
			write <= req_wr;
			addr  <= req_addr;
			wdata <= req_data;
		end else begin
			gate  <= 1'b0;
			write <= 1'b0;
			addr  <= ~addr;
			wdata <= ~wdata;
		end
	end
endmodule : dpm_user

// ### verif/tb.sv
// Purpose: Self-checking bench for the dual-port memory output pipeline.
// Assumes: Default stages: primitive and core registers on, no mux stages.
// Notes:   Port traffic goes through one user model per port.
`timescale 1ns/1ns

module tb;
	localparam int          LAT  = 1 + 1 + 0 + 1;
	localparam logic [31:0] IVAL = 32'h0000_1234;
	localparam logic [31:0] FVAL = 32'h0000_CAFE;
	localparam logic [31:0] CLRA = 32'h0000_A5A5;
	localparam logic [31:0] CLRB = 32'h0000_5A5A;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	wire  [31:0] hrdata;
	wire         hreadyout;
	wire         hresp;
	logic [1:0]  u_req;
	logic [1:0]  u_wr;
	logic [9:0]  u_addr [2];
	logic [31:0] u_data [2];
	logic [1:0]  clr_pin;
	logic        fin_b_pin;
	wire  [1:0]  p_gate;
	wire  [1:0]  p_wr;
	wire  [9:0]  p_addr [2];
	wire  [31:0] p_wdata [2];
	wire  [31:0] rdata [2];
	int          errors;
	int          cmp_count;

	////////////////////////////////////////////////////////////////////////
	// Init values are given in hex, aligned to the least significant bit.
	dpm_top #(.A_CLR_VALUE(CLRA), .B_CLR_VALUE(CLRB), .INIT_COUNT(4), .B_FINAL_PIN(1'b1),
		.INIT_VALUE(IVAL), .FILL_VALUE(FVAL)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.port_a_access_gate(p_gate[0]), .port_a_write(p_wr[0]),
		.port_a_addr(p_addr[0]), .port_a_wdata(p_wdata[0]),
		.port_a_final_stage_gate(1'b0), .port_a_output_clear(clr_pin[0]),
		.port_a_rdata(rdata[0]),
		.port_b_access_gate(p_gate[1]), .port_b_write(p_wr[1]),
		.port_b_addr(p_addr[1]), .port_b_wdata(p_wdata[1]),
		.port_b_final_stage_gate(fin_b_pin), .port_b_output_clear(clr_pin[1]),
		.port_b_rdata(rdata[1]));

	// One user model per port; index 0 is port A.
	for (genvar g = 0; g < 2; g++) begin : g_user
		dpm_user #(.AW(10), .W(32)) u_user (.hclk(hclk), .hresetn(hresetn),
			.req(u_req[g]), .req_wr(u_wr[g]), .req_addr(u_addr[g]),
			.req_data(u_data[g]), .gate(p_gate[g]), .write(p_wr[g]),
			.addr(p_addr[g]), .wdata(p_wdata[g]));
	end

	// Clock at 100 MHz.
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// Single AHB transfer; read data is taken at the edge that ends the data phase.
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : ahb

	// One request cycle of a port's user model.
	task automatic cyc(input int p, input logic rq, input logic w, input logic [9:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		u_req[p]  <= rq;
		u_wr[p]   <= w;
		u_addr[p] <= a;
		u_data[p] <= d;
	endtask : cyc

	// Looks at a port's output once the last edge has settled.
	task automatic look(input int p, input string what, input logic [31:0] exp);
		#1;
		check(what, exp, rdata[p]);
	endtask : look

	// Reads one address with the access gate held, so every stage moves except port B's pin-gated last one.
	task automatic rd(input int p, input logic [9:0] a, input logic [31:0] exp);
		repeat (LAT + 2) cyc(p, 1'b1, 1'b0, a, 32'h0000_0000);
		look(p, "read data", exp);
	endtask : rd

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [31:0] q;
		check("hreadyout", 32'h0000_0001, {31'h0, hreadyout});
		check("hresp", 32'h0000_0000, {31'h0, hresp});
		look(0, "reset rdata a", 32'h0000_0000);
		look(1, "reset rdata b", 32'h0000_0000);
		ahb(1'b0, `DPM_OFF_CTRL, 32'h0000_0000, q);
		check("ctrl", `DPM_CTRL_RESET, q);
		ahb(1'b0, `DPM_OFF_STATUS, 32'h0000_0000, q);
		check("latency", {16'h0000, 8'(LAT), 8'(LAT)}, q);
		ahb(1'b1, 32'h0000_0010, 32'hFFFF_FFFF, q);
		ahb(1'b0, 32'h0000_0010, 32'h0000_0000, q);
		check("unmapped", 32'h0000_0000, q);
		ahb(1'b0, `DPM_OFF_CTRL, 32'h0000_0000, q);
		check("ctrl kept", `DPM_CTRL_RESET, q);
		$display("t_reset done");
	endtask : t_reset

	// Back-to-back reads pin the latency to the exact edge.
	task automatic t_init();
		for (int p = 0; p < 2; p++) begin
			cyc(p, 1'b1, 1'b0, 10'h000, 32'h0000_0000);
			repeat (LAT + 1) cyc(p, 1'b1, 1'b0, 10'h005, 32'h0000_0000);
			look(p, "init word", IVAL);
			cyc(p, 1'b1, 1'b0, 10'h005, 32'h0000_0000);
			look(p, "fill word", FVAL);
			cyc(p, 1'b0, 1'b0, 10'h000, 32'h0000_0000);
		end
		$display("t_init done");
	endtask : t_init

	// Each write mode on each port, then the gate is dropped and output must stand.
	task automatic t_mode();
		logic [31:0] q;
		logic [9:0]  z;
		logic [31:0] vz;
		logic [31:0] vo;
		logic [31:0] vn;
		for (int m = 0; m < 3; m++) begin
			ahb(1'b1, `DPM_OFF_CTRL, {28'h0, 2'(m), 2'(m)}, q);
			for (int p = 0; p < 2; p++) begin
				z  = 10'(32 + 4 * m + 2 * p);
				vz = 32'h1111_0000 + 32'(16 * m + p);
				vo = 32'h2222_0000 + 32'(16 * m + p);
				vn = 32'h3333_0000 + 32'(16 * m + p);
				cyc(p, 1'b1, 1'b1, z, vz);
				cyc(p, 1'b1, 1'b1, z + 10'h001, vo);
				cyc(p, 1'b1, 1'b0, z, 32'h0000_0000);
				cyc(p, 1'b1, 1'b1, z + 10'h001, vn);
				repeat (LAT + 1) cyc(p, 1'b1, 1'b0, z, 32'h0000_0000);
				look(p, "mode out", (m == 0) ? vo : (m == 1) ? vn : vz);
				rd(p, z + 10'h001, vn);
				repeat (LAT + 2) cyc(p, 1'b0, 1'b0, 10'h000, 32'h0000_0000);
				look(p, "gated out", vn);
			end
		end
		$display("t_mode done");
	endtask : t_mode

	// Pin clear on port A, software clear on port B, both over an active gate.
	task automatic t_clear();
		logic [31:0] q;
		@(posedge hclk);
		clr_pin[0] <= 1'b1;
		ahb(1'b1, `DPM_OFF_CTRL, 32'h0000_0020, q);
		fork
			rd(0, 10'h000, CLRA);
			rd(1, 10'h000, CLRB);
		join
		@(posedge hclk);
		clr_pin[0] <= 1'b0;
		ahb(1'b1, `DPM_OFF_CTRL, 32'h0000_0000, q);
		rd(0, 10'h000, IVAL);
		rd(1, 10'h000, IVAL);
		$display("t_clear done");
	endtask : t_clear

	// Port B's last stage follows its own gate pin alone, even while reads go on.
	task automatic t_final();
		@(posedge hclk);
		fin_b_pin <= 1'b0;
		rd(1, 10'h005, IVAL);
		@(posedge hclk);
		fin_b_pin <= 1'b1;
		rd(1, 10'h005, FVAL);
		$display("t_final done");
	endtask : t_final

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////////////////
	// Main sequence; every input has a value at time zero.
	initial begin
		errors = 0;
		cmp_count = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		u_req = 2'b00;
		u_wr = 2'b00;
		u_addr = '{10'h000, 10'h000};
		u_data = '{32'h0000_0000, 32'h0000_0000};
		clr_pin = 2'b00;
		fin_b_pin = 1'b1;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1;
		t_reset();
		t_init();
		t_mode();
		t_clear();
		t_final();
		print_verdict();
	end

	// The run needs well under two thousand cycles; a hang ends here.
	initial begin
		#200000;
		errors++;
		print_verdict();
	end
endmodule : tb
